/* File: scc_pkg.sv */
// shared constants and state encoding for sleep and configuration-source control
package scc_pkg;
    // clock
    localparam int CLK_PERIOD_PS = 4000;
    // timing figures in ns and derived cycle counts (least times round up)
    localparam int SLEEP_ENTER_NS  = 300;
    localparam int SLEEP_ENTER_CYC = (SLEEP_ENTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int GLITCH_NS       = 50;
    localparam int GLITCH_CYC      = (GLITCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WAKE_NS         = 1000;
    localparam int WAKE_CYC        = (WAKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TIMER_W         = 16;
    // configuration image geometry
    localparam int CFG_DEPTH       = 256;
    localparam int CFG_WIDTH       = 8;
    localparam int BIT_CNT_W       = 3;
    // reset values
    localparam logic PIN_HIGH_RST  = 1'b1;
    localparam logic PIN_LOW_RST   = 1'b0;

    typedef enum logic [6:0] {
        S_OFF    = 7'h01,
        S_LOAD   = 7'h02,
        S_RUN    = 7'h04,
        S_DIRECT = 7'h08,
        S_ENTER  = 7'h10,
        S_SLEEP  = 7'h20,
        S_WAKE   = 7'h40
    } scc_state_t;
endpackage

/* File: scc_cfg_mem.sv */
// small configuration memory with registered read data
`timescale 1ns/100ps
module scc_cfg_mem #(
    parameter int WIDTH = scc_pkg::CFG_WIDTH,
    parameter int DEPTH = scc_pkg::CFG_DEPTH,
    parameter int AW    = $clog2(scc_pkg::CFG_DEPTH)
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // write port
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    // read port
    input  wire logic             rd_en,
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data_ff
);
    logic [WIDTH-1:0] mem [DEPTH];

    initial begin
        if (DEPTH < 2 || DEPTH > (1 << AW)) begin
            $error("scc_cfg_mem: depth does not fit address width");
        end
    end

    // array has no reset: contents are only meaningful once written
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_ff <= '0;
        end else if (rd_en) begin
            rd_data_ff <= mem[rd_addr];
        end
    end
endmodule

/* File: scc_sleep_cfg_ctrl.sv */
// device power mode sequencing and configuration source control
`timescale 1ns/100ps

module scc_sleep_cfg_ctrl #(
    parameter int DEPTH      = scc_pkg::CFG_DEPTH,
    parameter int GLITCH_CYC = scc_pkg::GLITCH_CYC,
    parameter int ENTER_CYC  = scc_pkg::SLEEP_ENTER_CYC,
    parameter int WAKE_CYC   = scc_pkg::WAKE_CYC
) (
    // clock and reset
    input  wire logic                           clk,
    input  wire logic                           rst_n,
    // asynchronous pins
    input  wire logic                           sleep_request_n,
    input  wire logic                           supplies_valid,
    // test access port configuration stream (serial)
    input  wire logic                           tap_start,
    input  wire logic                           tap_stop,
    input  wire logic                           tap_to_nvm,
    input  wire logic                           tap_bit_valid,
    input  wire logic                           tap_bit,
    // dedicated configuration port stream
    input  wire logic                           dcp_start,
    input  wire logic                           dcp_stop,
    input  wire logic                           dcp_to_nvm,
    input  wire logic                           dcp_byte_mode,
    input  wire logic                           dcp_valid,
    input  wire logic [scc_pkg::CFG_WIDTH-1:0]  dcp_data,
    // configuration readback
    input  wire logic [$clog2(DEPTH)-1:0]       cfg_rd_addr,
    output logic      [scc_pkg::CFG_WIDTH-1:0]  cfg_rd_data_ff,
    // status and control outputs
    output logic                                user_run_ff,
    output logic                                user_rst_n_ff,
    output logic                                io_drive_en_ff,
    output logic                                clamp_en_ff,
    output logic                                prog_ready_ff,
    output logic                                cfg_done_ff,
    output logic                                sleeping_ff,
    output logic                                bg_prog_busy_ff
);
    localparam int AW = $clog2(DEPTH);
    localparam int TW = scc_pkg::TIMER_W;
    localparam int WD = scc_pkg::CFG_WIDTH;

    initial begin
        if (DEPTH < 2 || GLITCH_CYC < 1 || ENTER_CYC < 1 || WAKE_CYC < 1 ||
            ENTER_CYC >= (1 << TW) || WAKE_CYC >= (1 << TW) || GLITCH_CYC >= (1 << TW)) begin
            $error("scc_sleep_cfg_ctrl: unsupported parameter value");
        end
    end

    // pin synchronisers: a change counts once stages two and three agree
    logic [2:0] slp_sync_ff;
    logic [2:0] pwr_sync_ff;
    logic       pwr_ok_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slp_sync_ff <= {3{scc_pkg::PIN_HIGH_RST}};
            pwr_sync_ff <= {3{scc_pkg::PIN_LOW_RST}};
        end else begin
            slp_sync_ff <= {slp_sync_ff[1:0], sleep_request_n};
            pwr_sync_ff <= {pwr_sync_ff[1:0], supplies_valid};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_ok_ff <= scc_pkg::PIN_LOW_RST;
        end else if (pwr_sync_ff[1] == pwr_sync_ff[2]) begin
            pwr_ok_ff <= pwr_sync_ff[2];
        end
    end

    // glitch filter: the level must hold GLITCH_CYC cycles before it is believed
    logic          slp_filt_n_ff;
    logic [TW-1:0] glitch_cnt_ff;
    logic          slp_req;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slp_filt_n_ff <= scc_pkg::PIN_HIGH_RST;
            glitch_cnt_ff <= '0;
        end else if (slp_sync_ff[1] == slp_sync_ff[2] && slp_sync_ff[2] != slp_filt_n_ff) begin
            if (glitch_cnt_ff == TW'(GLITCH_CYC - 1)) begin
                slp_filt_n_ff <= slp_sync_ff[2];
                glitch_cnt_ff <= '0;
            end else begin
                glitch_cnt_ff <= glitch_cnt_ff + TW'(1);
            end
        end else begin
            glitch_cnt_ff <= '0;
        end
    end

    assign slp_req = !slp_filt_n_ff;

    // configuration session bookkeeping
    scc_pkg::scc_state_t state_ff;
    scc_pkg::scc_state_t nxt_state;
    logic                sess_active_ff;
    logic                sess_tap_ff;
    logic                sess_nvm_ff;
    logic [AW:0]         sess_addr_ff;
    logic [WD-1:0]       shift_ff;
    logic [scc_pkg::BIT_CNT_W-1:0] bit_cnt_ff;
    logic                prog_open;
    logic                start_any;
    logic                start_nvm;
    logic                stop_any;
    logic                ser_valid;
    logic                ser_bit;
    logic                byte_wr;
    logic [WD-1:0]       byte_data;

    assign prog_open = (state_ff == scc_pkg::S_RUN) || (state_ff == scc_pkg::S_DIRECT);
    // test port wins when both ports start together
    assign start_any = prog_open && !sess_active_ff && (tap_start || dcp_start);
    assign start_nvm = tap_start ? tap_to_nvm : dcp_to_nvm;
    assign stop_any  = sess_active_ff && (sess_tap_ff ? tap_stop : dcp_stop);
    assign ser_valid = sess_tap_ff ? tap_bit_valid : (dcp_valid && !dcp_byte_mode);
    assign ser_bit   = sess_tap_ff ? tap_bit : dcp_data[0];

    always_comb begin
        byte_wr   = 1'b0;
        byte_data = {shift_ff[WD-2:0], ser_bit};
        if (sess_active_ff && !sess_addr_ff[AW]) begin
            if (!sess_tap_ff && dcp_valid && dcp_byte_mode) begin
                byte_wr   = 1'b1;
                byte_data = dcp_data;
            end else if (ser_valid && bit_cnt_ff == scc_pkg::BIT_CNT_W'(WD - 1)) begin
                byte_wr   = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sess_active_ff <= 1'b0;
            sess_tap_ff    <= 1'b0;
            sess_nvm_ff    <= 1'b0;
        end else if (!prog_open || stop_any) begin
            sess_active_ff <= 1'b0;
        end else if (start_any) begin
            sess_active_ff <= 1'b1;
            sess_tap_ff    <= tap_start;
            sess_nvm_ff    <= start_nvm;
        end
    end

    // serial bits pack msb first; bytes beyond the image are dropped
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sess_addr_ff <= '0;
            shift_ff     <= '0;
            bit_cnt_ff   <= '0;
        end else if (start_any) begin
            sess_addr_ff <= '0;
            shift_ff     <= '0;
            bit_cnt_ff   <= '0;
        end else if (sess_active_ff) begin
            if (ser_valid) begin
                shift_ff   <= byte_data;
                bit_cnt_ff <= bit_cnt_ff + scc_pkg::BIT_CNT_W'(1);
            end
            if (byte_wr) begin
                sess_addr_ff <= sess_addr_ff + (AW + 1)'(1);
            end
        end
    end

    // power-up and wake reload engine: nvm read has one cycle latency
    logic [AW:0]   ld_addr_ff;
    logic          ld_pend_ff;
    logic [AW-1:0] ld_wa_ff;
    logic          ld_issue;
    logic          ld_done;
    logic [WD-1:0] nvm_rd_data;

    assign ld_issue = (state_ff == scc_pkg::S_LOAD) && !ld_addr_ff[AW];
    assign ld_done  = ld_pend_ff && (ld_wa_ff == AW'(DEPTH - 1));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ld_addr_ff <= '0;
            ld_pend_ff <= 1'b0;
            ld_wa_ff   <= '0;
        end else if (state_ff != scc_pkg::S_LOAD) begin
            ld_addr_ff <= '0;
            ld_pend_ff <= 1'b0;
        end else begin
            ld_pend_ff <= ld_issue;
            ld_wa_ff   <= ld_addr_ff[AW-1:0];
            if (ld_issue) begin
                ld_addr_ff <= (ld_addr_ff == (AW + 1)'(DEPTH - 1)) ?
                              {1'b1, AW'(0)} : ld_addr_ff + (AW + 1)'(1);
            end
        end
    end

    // memories: volatile image and non-volatile store
    logic          sram_we;
    logic [AW-1:0] sram_wa;
    logic [WD-1:0] sram_wd;
    logic          nvm_we;

    assign sram_we = (state_ff == scc_pkg::S_LOAD) ? ld_pend_ff : (byte_wr && !sess_nvm_ff);
    assign sram_wa = (state_ff == scc_pkg::S_LOAD) ? ld_wa_ff : sess_addr_ff[AW-1:0];
    assign sram_wd = (state_ff == scc_pkg::S_LOAD) ? nvm_rd_data : byte_data;
    assign nvm_we  = byte_wr && sess_nvm_ff;

    scc_cfg_mem #(.WIDTH(WD), .DEPTH(DEPTH), .AW(AW)) u_sram (
        .clk        (clk),
        .rst_n      (rst_n),
        .wr_en      (sram_we),
        .wr_addr    (sram_wa),
        .wr_data    (sram_wd),
        .rd_en      (1'b1),
        .rd_addr    (cfg_rd_addr),
        .rd_data_ff (cfg_rd_data_ff)
    );

    scc_cfg_mem #(.WIDTH(WD), .DEPTH(DEPTH), .AW(AW)) u_nvm (
        .clk        (clk),
        .rst_n      (rst_n),
        .wr_en      (nvm_we),
        .wr_addr    (sess_addr_ff[AW-1:0]),
        .wr_data    (byte_data),
        .rd_en      (ld_issue),
        .rd_addr    (ld_addr_ff[AW-1:0]),
        .rd_data_ff (nvm_rd_data)
    );

    // mode sequencer
    logic [TW-1:0] tmr_ff;
    logic          cfg_ok_ff;
    logic          nxt_cfg_ok;
    logic          tmr_done;

    assign tmr_done = (tmr_ff == '0);

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            scc_pkg::S_OFF: begin
                nxt_state = scc_pkg::S_LOAD;
            end
            scc_pkg::S_LOAD: begin
                if (slp_req) begin
                    nxt_state = scc_pkg::S_ENTER;
                end else if (ld_done) begin
                    nxt_state = scc_pkg::S_RUN;
                end
            end
            scc_pkg::S_RUN: begin
                if (slp_req) begin
                    nxt_state = scc_pkg::S_ENTER;
                end else if (start_any && !start_nvm) begin
                    nxt_state = scc_pkg::S_DIRECT;
                end
            end
            scc_pkg::S_DIRECT: begin
                if (slp_req) begin
                    nxt_state = scc_pkg::S_ENTER;
                end else if (stop_any) begin
                    nxt_state = scc_pkg::S_RUN;
                end
            end
            scc_pkg::S_ENTER: begin
                // a release before the entry delay returns to run with state intact if the image was valid, otherwise it reloads
                if (!slp_req) begin
                    nxt_state = cfg_ok_ff ? scc_pkg::S_RUN : scc_pkg::S_LOAD;
                end else if (tmr_done) begin
                    nxt_state = scc_pkg::S_SLEEP;
                end
            end
            scc_pkg::S_SLEEP: begin
                if (!slp_req) begin
                    nxt_state = scc_pkg::S_WAKE;
                end
            end
            scc_pkg::S_WAKE: begin
                if (slp_req) begin
                    nxt_state = scc_pkg::S_SLEEP;
                end else if (tmr_done) begin
                    nxt_state = scc_pkg::S_LOAD;
                end
            end
        endcase
        if (!pwr_ok_ff) begin
            nxt_state = scc_pkg::S_OFF;
        end
    end

    always_comb begin
        nxt_cfg_ok = cfg_ok_ff;
        if (nxt_state == scc_pkg::S_OFF || nxt_state == scc_pkg::S_SLEEP ||
            nxt_state == scc_pkg::S_LOAD || nxt_state == scc_pkg::S_DIRECT) begin
            nxt_cfg_ok = 1'b0;
        end else if (nxt_state == scc_pkg::S_RUN) begin
            nxt_cfg_ok = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff  <= scc_pkg::S_OFF;
            cfg_ok_ff <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            cfg_ok_ff <= nxt_cfg_ok;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tmr_ff <= '0;
        end else if (nxt_state == scc_pkg::S_ENTER && state_ff != scc_pkg::S_ENTER) begin
            tmr_ff <= TW'(ENTER_CYC - 1);
        end else if (nxt_state == scc_pkg::S_WAKE && state_ff != scc_pkg::S_WAKE) begin
            tmr_ff <= TW'(WAKE_CYC - 1);
        end else if (!tmr_done) begin
            tmr_ff <= tmr_ff - TW'(1);
        end
    end

    // registered outputs, derived from the next state except bg_prog_busy_ff, which follows the current state and session
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            user_run_ff     <= 1'b0;
            user_rst_n_ff   <= 1'b0;
            io_drive_en_ff  <= 1'b0;
            clamp_en_ff     <= 1'b0;
            prog_ready_ff   <= 1'b0;
            cfg_done_ff     <= 1'b0;
            sleeping_ff     <= 1'b0;
            bg_prog_busy_ff <= 1'b0;
        end else begin
            user_run_ff     <= (nxt_state == scc_pkg::S_RUN) || (nxt_state == scc_pkg::S_ENTER &&
                               cfg_ok_ff);
            // user registers are lost whenever the image is not valid
            user_rst_n_ff   <= nxt_cfg_ok;
            io_drive_en_ff  <= nxt_cfg_ok && nxt_state != scc_pkg::S_SLEEP;
            clamp_en_ff     <= pwr_ok_ff && nxt_cfg_ok;
            prog_ready_ff   <= (nxt_state == scc_pkg::S_RUN) || (nxt_state == scc_pkg::S_DIRECT);
            cfg_done_ff     <= nxt_cfg_ok;
            sleeping_ff     <= (nxt_state == scc_pkg::S_SLEEP);
            bg_prog_busy_ff <= prog_open && !stop_any &&
                               (sess_active_ff ? sess_nvm_ff : (start_any && start_nvm));
        end
    end
endmodule

/* File: scc_sleep_cfg_ctrl_chk.sv */
// port-level assertions for sleep and configuration-source control
`timescale 1ns/100ps
module scc_chk #(
    parameter int GLITCH_CYC = scc_pkg::GLITCH_CYC,
    parameter int ENTER_CYC  = scc_pkg::SLEEP_ENTER_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins and session starts
    input wire logic sleep_request_n,
    input wire logic supplies_valid,
    input wire logic tap_start,
    input wire logic tap_to_nvm,
    input wire logic dcp_start,
    input wire logic dcp_to_nvm,
    // status
    input wire logic user_run_ff,
    input wire logic user_rst_n_ff,
    input wire logic io_drive_en_ff,
    input wire logic clamp_en_ff,
    input wire logic prog_ready_ff,
    input wire logic cfg_done_ff,
    input wire logic sleeping_ff,
    input wire logic bg_prog_busy_ff
);
    // slack covers the synchroniser stages and the state register
    localparam int ENTER_MAX = GLITCH_CYC + ENTER_CYC + 8;
    localparam int PAST_LOW  = GLITCH_CYC + ENTER_CYC;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_low_held; user_run_ff ##1 !sleep_request_n [*8]; endsequence
    sequence s_idle; prog_ready_ff && user_run_ff && !bg_prog_busy_ff; endsequence
    property p_enter; s_low_held |-> ##[0:ENTER_MAX]
        (sleeping_ff || sleep_request_n || !supplies_valid); endproperty
    a_enter: assert property (p_enter) else $error("sleep not entered in time");
    property p_asleep; sleeping_ff |-> !user_run_ff && !io_drive_en_ff && !user_rst_n_ff
        && !cfg_done_ff && !prog_ready_ff && !bg_prog_busy_ff; endproperty
    a_asleep: assert property (p_asleep) else $error("activity while asleep");
    property p_glitch; $rose(sleeping_ff) |-> !$past(sleep_request_n, PAST_LOW); endproperty
    a_glitch: assert property (p_glitch) else $error("sleep on short pulse");
    property p_wake; $rose(sleep_request_n) && sleeping_ff |=> !user_run_ff [*6]; endproperty
    a_wake: assert property (p_wake) else $error("woke too early");
    property p_run; user_run_ff |-> cfg_done_ff && user_rst_n_ff && io_drive_en_ff; endproperty
    a_run: assert property (p_run) else $error("running without image");
    property p_power; !supplies_valid [*8] |-> !clamp_en_ff && !io_drive_en_ff
        && !cfg_done_ff; endproperty
    a_power: assert property (p_power) else $error("active without supplies");
    property p_direct; s_idle ##0 (tap_start ? !tap_to_nvm : dcp_start && !dcp_to_nvm)
        |=> !user_run_ff && !io_drive_en_ff && !cfg_done_ff; endproperty
    a_direct: assert property (p_direct) else $error("direct load kept running");
    property p_bg; s_idle ##0 (tap_start ? tap_to_nvm : dcp_start && dcp_to_nvm)
        |=> bg_prog_busy_ff && user_run_ff; endproperty
    a_bg: assert property (p_bg) else $error("background program disturbed");
endmodule

bind scc_sleep_cfg_ctrl scc_chk #(.GLITCH_CYC(GLITCH_CYC), .ENTER_CYC(ENTER_CYC)) i_scc_chk (
    .clk(clk), .rst_n(rst_n), .sleep_request_n(sleep_request_n),
    .supplies_valid(supplies_valid), .tap_start(tap_start), .tap_to_nvm(tap_to_nvm),
    .dcp_start(dcp_start), .dcp_to_nvm(dcp_to_nvm), .user_run_ff(user_run_ff),
    .user_rst_n_ff(user_rst_n_ff), .io_drive_en_ff(io_drive_en_ff),
    .clamp_en_ff(clamp_en_ff), .prog_ready_ff(prog_ready_ff), .cfg_done_ff(cfg_done_ff),
    .sleeping_ff(sleeping_ff), .bg_prog_busy_ff(bg_prog_busy_ff)
);

/* File: scc_board.sv */
// board controller model: sleep pin, supplies and both configuration ports
`timescale 1ns/100ps
module scc_board #(
    parameter int DEPTH = 4
) (
    // clock
    input  wire logic  clk,
    // pins
    output logic       sleep_request_n,
    output logic       supplies_valid,
    // test port stream
    output logic       tap_start,
    output logic       tap_stop,
    output logic       tap_to_nvm,
    output logic       tap_bit_valid,
    output logic       tap_bit,
    // dedicated port stream
    output logic       dcp_start,
    output logic       dcp_stop,
    output logic       dcp_to_nvm,
    output logic       dcp_byte_mode,
    output logic       dcp_valid,
    output logic [7:0] dcp_data
);
    initial begin
        {sleep_request_n, supplies_valid} = 2'h3;
        {tap_start, tap_stop, tap_to_nvm, tap_bit_valid, tap_bit} = 5'h00;
        {dcp_start, dcp_stop, dcp_to_nvm, dcp_byte_mode, dcp_valid} = 5'h00;
        dcp_data = 8'h00;
    end
    task automatic pins(input logic slp_n, input logic sup);
        @(posedge clk);
        sleep_request_n <= slp_n;
        supplies_valid  <= sup;
    endtask
    // one session: start, DEPTH bytes, stop; test port is serial only
    task automatic send(input logic dcp, input logic nvm, input logic bm,
                        input logic [8*DEPTH-1:0] img);
        @(posedge clk);
        tap_start     <= !dcp;
        dcp_start     <= dcp;
        tap_to_nvm    <= nvm;
        dcp_to_nvm    <= nvm;
        dcp_byte_mode <= dcp && bm;
        for (int i = 0; i < DEPTH; i++) begin
            for (int b = 7; b >= 0; b = (dcp && bm) ? -1 : b - 1) begin
                @(posedge clk);
                {tap_start, dcp_start} <= 2'h0;
                tap_bit_valid <= !dcp;
                dcp_valid     <= dcp;
                tap_bit       <= img[8*i+b];
                dcp_data      <= bm ? img[8*i +: 8] : {7'h00, img[8*i+b]};
            end
        end
        @(posedge clk);
        {tap_bit_valid, dcp_valid} <= 2'h0;
        {tap_stop, dcp_stop} <= {!dcp, dcp};
        // released data lines must not keep looking valid
        tap_bit  <= ~tap_bit;
        dcp_data <= ~dcp_data;
        @(posedge clk);
        {tap_stop, dcp_stop} <= 2'h0;
    endtask
endmodule

/* File: scc_sleep_cfg_ctrl_tb.sv */
// self-checking testbench for sleep and configuration-source control
`timescale 1ns/100ps
module scc_sleep_cfg_ctrl_tb;
    localparam int          DEPTH = 4;
    localparam logic [31:0] IMG_D = 32'h2db4_96e1;
    logic       clk;
    logic       rst_n;
    logic [1:0] cfg_rd_addr;
    logic [7:0] cfg_rd_data_ff, dcp_data;
    logic       sleep_request_n, supplies_valid, tap_start, tap_stop, tap_to_nvm;
    logic       tap_bit_valid, tap_bit, dcp_start, dcp_stop, dcp_to_nvm, dcp_byte_mode;
    logic       dcp_valid, user_run_ff, user_rst_n_ff, io_drive_en_ff, clamp_en_ff;
    logic       prog_ready_ff, cfg_done_ff, sleeping_ff, bg_prog_busy_ff;
    int         num_errors = 0;
    int         n_tests = 0;
    int         cycles = 0;

    scc_sleep_cfg_ctrl #(.DEPTH(DEPTH), .GLITCH_CYC(2), .ENTER_CYC(3), .WAKE_CYC(4))
    i_scc_sleep_cfg_ctrl (
        .clk(clk), .rst_n(rst_n), .sleep_request_n(sleep_request_n),
        .supplies_valid(supplies_valid), .tap_start(tap_start), .tap_stop(tap_stop),
        .tap_to_nvm(tap_to_nvm), .tap_bit_valid(tap_bit_valid), .tap_bit(tap_bit),
        .dcp_start(dcp_start), .dcp_stop(dcp_stop), .dcp_to_nvm(dcp_to_nvm),
        .dcp_byte_mode(dcp_byte_mode), .dcp_valid(dcp_valid), .dcp_data(dcp_data),
        .cfg_rd_addr(cfg_rd_addr), .cfg_rd_data_ff(cfg_rd_data_ff),
        .user_run_ff(user_run_ff), .user_rst_n_ff(user_rst_n_ff),
        .io_drive_en_ff(io_drive_en_ff), .clamp_en_ff(clamp_en_ff),
        .prog_ready_ff(prog_ready_ff), .cfg_done_ff(cfg_done_ff),
        .sleeping_ff(sleeping_ff), .bg_prog_busy_ff(bg_prog_busy_ff)
    );
    scc_board #(.DEPTH(DEPTH)) i_scc_board (
        .clk(clk), .sleep_request_n(sleep_request_n), .supplies_valid(supplies_valid),
        .tap_start(tap_start), .tap_stop(tap_stop), .tap_to_nvm(tap_to_nvm),
        .tap_bit_valid(tap_bit_valid), .tap_bit(tap_bit), .dcp_start(dcp_start),
        .dcp_stop(dcp_stop), .dcp_to_nvm(dcp_to_nvm), .dcp_byte_mode(dcp_byte_mode),
        .dcp_valid(dcp_valid), .dcp_data(dcp_data)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            $display("ERROR timeout expected finish seen hang");
            num_errors++;
            finish_test();
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            num_errors++;
        end
    endtask
    // order: run, io drive, clamp, prog ready, sleeping
    task automatic st(input logic [4:0] exp);
        check("status", {27'h0, exp},
              {27'h0, user_run_ff, io_drive_en_ff, clamp_en_ff, prog_ready_ff, sleeping_ff});
    endtask
    // samples at falling edges so rising-edge updates have landed
    task automatic wait_on(input bit slp, input int lim);
        for (int k = 0; k < lim; k++) begin
            @(negedge clk);
            if ((slp ? sleeping_ff : cfg_done_ff) === 1'b1) return;
        end
    endtask
    task automatic rd_img(input logic [31:0] img);
        for (int a = 0; a < DEPTH; a++) begin
            @(posedge clk);
            cfg_rd_addr <= a[1:0];
            @(posedge clk);
            @(negedge clk);
            check("cfg_rd_data_ff", {24'h0, img[8*a +: 8]}, {24'h0, cfg_rd_data_ff});
        end
    endtask
    task automatic t_power_up;
        wait_on(1'b0, 40);
        st(5'b11110);
        check("user_rst_n_ff", 32'h1, {31'h0, user_rst_n_ff});
        $display("test power_up done");
    endtask
    // nvm session while user logic must keep running
    task automatic t_bg(input string name, input logic dcp, input logic [31:0] img);
        fork
            i_scc_board.send(dcp, 1'b1, 1'b0, img);
            begin
                repeat (4) @(negedge clk);
                check("bg_prog_busy_ff", 32'h1, {31'h0, bg_prog_busy_ff});
                st(5'b11110);
            end
        join
        @(negedge clk);
        check("bg_prog_busy_ff", 32'h0, {31'h0, bg_prog_busy_ff});
        $display("test %s done", name);
    endtask
    // volatile image loaded directly, user logic stopped meanwhile
    task automatic t_direct(input string name, input logic dcp, input logic bm,
                            input logic [31:0] img);
        fork
            i_scc_board.send(dcp, 1'b0, bm, img);
            begin
                repeat (4) @(negedge clk);
                st(5'b00010);
            end
        join
        wait_on(1'b0, 8);
        st(5'b11110);
        rd_img(img);
        $display("test %s done", name);
    endtask
    task automatic t_glitch;
        i_scc_board.pins(1'b0, 1'b1);
        i_scc_board.pins(1'b0, 1'b1);
        i_scc_board.pins(1'b1, 1'b1);
        // two low cycles get through the synchroniser but fall short of the filter count
        repeat (12) begin
            @(negedge clk);
            st(5'b11110);
        end
        $display("test glitch done");
    endtask
    task automatic t_sleep;
        i_scc_board.pins(1'b0, 1'b1);
        wait_on(1'b1, 40);
        st(5'b00001);
        check("cfg_done user_rst_n bg", 32'h0,
              {29'h0, cfg_done_ff, user_rst_n_ff, bg_prog_busy_ff});
        i_scc_board.pins(1'b1, 1'b1);
        repeat (6) @(negedge clk);
        check("user_run_ff", 32'h0, {31'h0, user_run_ff});
        wait_on(1'b0, 40);
        st(5'b11110);
        rd_img(IMG_D);
        $display("test sleep done");
    endtask
    task automatic t_power_cycle;
        i_scc_board.pins(1'b1, 1'b0);
        repeat (10) @(negedge clk);
        st(5'b00000);
        check("cfg_done_ff", 32'h0, {31'h0, cfg_done_ff});
        i_scc_board.pins(1'b1, 1'b1);
        wait_on(1'b0, 40);
        st(5'b11110);
        rd_img(IMG_D);
        $display("test power_cycle done");
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        rst_n = 1'b0;
        cfg_rd_addr = 2'h0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_power_up();
        t_bg("tap_nvm", 1'b0, 32'h5a3c_81e7);
        t_direct("dcp_byte_direct", 1'b1, 1'b1, 32'hc311_7ea5);
        t_direct("tap_serial_direct", 1'b0, 1'b0, 32'h0ff0_6996);
        t_direct("dcp_serial_direct", 1'b1, 1'b0, 32'h8421_b77e);
        t_bg("dcp_nvm", 1'b1, IMG_D);
        t_glitch();
        t_sleep();
        t_power_cycle();
        finish_test();
    end
endmodule
